// *** shared/ifsb_defines.vh ***
`ifndef IFSB_DEFINES_VH
`define IFSB_DEFINES_VH

// bus geometry
`define IFSB_AW          8
`define IFSB_DW          32
`define IFSB_FW          16
`define IFSB_EW          4

// register byte offsets
`define IFSB_OFS_FLAGS0  8'h00
`define IFSB_OFS_FLAGS1  8'h04
`define IFSB_OFS_FLAGS2  8'h08
`define IFSB_OFS_FLAGS3  8'h0C
`define IFSB_OFS_STATUS  8'h10
`define IFSB_OFS_CLEAR   8'h14
`define IFSB_OFS_ENABLE  8'h18

// register select codes
`define IFSB_SEL_F0      3'h0
`define IFSB_SEL_F1      3'h1
`define IFSB_SEL_F2      3'h2
`define IFSB_SEL_F3      3'h3
`define IFSB_SEL_STAT    3'h4
`define IFSB_SEL_CLR     3'h5
`define IFSB_SEL_EN      3'h6
`define IFSB_SEL_NONE    3'h7

// implemented-bit masks and reset values
`define IFSB_MASK0       16'h3FEF
`define IFSB_MASK1       16'hFEDF
`define IFSB_MASK2       16'h3FE3
`define IFSB_MASK3       16'h4066
`define IFSB_FLAG_RST    16'h0000
`define IFSB_EVT_RST     4'h0
`define IFSB_ZERO32      32'h00000000

// axi responses
`define IFSB_RESP_OKAY   2'b00
`define IFSB_RESP_SLVERR 2'b10

// flag register 0 bit positions
`define IFSB_ADC_DONE    13
`define IFSB_UART_A_TX   12
`define IFSB_UART_A_RX   11
`define IFSB_SPI_A_EVT   10
`define IFSB_SPI_A_FLT   9
`define IFSB_TIMER_C     8
`define IFSB_TIMER_B     7
`define IFSB_CMP_B       6
`define IFSB_CAP_B       5
`define IFSB_TIMER_A     3
`define IFSB_CMP_A       2
`define IFSB_CAP_A       1
`define IFSB_EXT_A       0
// flag register 1 bit positions
`define IFSB_UART_B_TX   15
`define IFSB_UART_B_RX   14
`define IFSB_EXT_C       13
`define IFSB_TIMER_E     12
`define IFSB_TIMER_D     11
`define IFSB_CMP_D       10
`define IFSB_CMP_C       9
`define IFSB_CAP_H       7
`define IFSB_CAP_G       6
`define IFSB_EXT_B       4
`define IFSB_PIN_CHG     3
`define IFSB_COMPARATOR  2
`define IFSB_I2C_A_MST   1
`define IFSB_I2C_A_SLV   0
// flag register 2 bit positions
`define IFSB_PAR_PORT    13
`define IFSB_CMP_H       12
`define IFSB_CMP_G       11
`define IFSB_CMP_F       10
`define IFSB_CMP_E       9
`define IFSB_CAP_F       8
`define IFSB_CAP_E       7
`define IFSB_CAP_D       6
`define IFSB_CAP_C       5
`define IFSB_SPI_B_EVT   1
`define IFSB_SPI_B_FLT   0
// flag register 3 bit positions
`define IFSB_CALENDAR    14
`define IFSB_EXT_E       6
`define IFSB_EXT_D       5
`define IFSB_I2C_B_MST   2
`define IFSB_I2C_B_SLV   1

`endif

// *** logic/ifsb_flag_reg.v ***
`timescale 1ns/1ps
`include "ifsb_defines.vh"

// one 16-bit sticky flag register with per-lane software write
module ifsb_flag_reg #(
   parameter [15:0] MASK = 16'hFFFF // implemented bits
) (
   input  wire        clock,
   input  wire        reset_n,
   input  wire        wr,     // software write strobe
   input  wire [15:0] wdata,  // software write value
   input  wire [1:0]  wstrb,  // byte lanes
   input  wire [15:0] req,    // peripheral requests
   output reg  [15:0] flags,  // held flags
   output wire        evt     // a new request latched
);
   reg [15:0] next_flags;

   // new pending request on an idle bit
   assign evt = |(req & MASK & ~flags);

   // software value per lane, then requests on top
   always @* begin
      next_flags = flags;
      if (wr && wstrb[0]) begin
         next_flags[7:0] = wdata[7:0]; // RULE4
      end
      if (wr && wstrb[1]) begin
         next_flags[15:8] = wdata[15:8]; // RULE4
      end
      next_flags = (next_flags | req) & MASK; // RULE13
   end

   // clocked store, cleared at reset
   always @(posedge clock) begin
      if (!reset_n) begin
         flags <= `IFSB_FLAG_RST; // RULE3
      end else begin
         flags <= next_flags; // RULE12
      end
   end
endmodule

// *** logic/ifsb_axi_slave.v ***
`timescale 1ns/1ps
`include "ifsb_defines.vh"

// axi4-lite slave front end: one write and one read at a time
module ifsb_axi_slave (
   input  wire                 clock,
   input  wire                 reset_n,
   input  wire                 awvalid,
   output wire                 awready,
   input  wire [`IFSB_AW-1:0]  awaddr,
   input  wire                 wvalid,
   output wire                 wready,
   input  wire [`IFSB_DW-1:0]  wdata,
   input  wire [3:0]           wstrb,
   output reg                  bvalid,
   input  wire                 bready,
   output reg  [1:0]           bresp,
   input  wire                 arvalid,
   output wire                 arready,
   input  wire [`IFSB_AW-1:0]  araddr,
   output wire                 rvalid,
   input  wire                 rready,
   output reg  [`IFSB_DW-1:0]  rdata,
   output reg  [1:0]           rresp,
   output wire                 wr_en,   // one-cycle register write
   output reg  [`IFSB_AW-1:0]  wr_addr,
   output reg  [`IFSB_DW-1:0]  wr_data,
   output reg  [3:0]           wr_strb,
   input  wire                 wr_err,
   output wire                 rd_en,   // one-cycle register read
   input  wire [`IFSB_DW-1:0]  rd_data,
   input  wire                 rd_err
);
   localparam [1:0] RD_IDLE = 2'b01;
   localparam [1:0] RD_RESP = 2'b10;

   reg       aw_full; // address held
   reg       w_full;  // data held
   reg [1:0] rd_state;

   assign awready = !aw_full;
   assign wready  = !w_full;
   assign wr_en   = aw_full && w_full && !bvalid;
   assign arready = rd_state[0];
   assign rvalid  = rd_state[1];
   assign rd_en   = arvalid && arready;

   // write channels, taken in either order
   always @(posedge clock) begin
      if (!reset_n) begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `IFSB_RESP_OKAY;
         wr_addr <= {`IFSB_AW{1'b0}};
         wr_data <= `IFSB_ZERO32;
         wr_strb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_full  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en) begin // perform and answer
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_err ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
         end
      end
   end

   // read channel state machine
   always @(posedge clock) begin
      if (!reset_n) begin
         rd_state <= RD_IDLE;
         rdata    <= `IFSB_ZERO32;
         rresp    <= `IFSB_RESP_OKAY;
      end else begin
         case (rd_state)
            RD_IDLE: begin
               if (rd_en) begin
                  rdata    <= rd_data;
                  rresp    <= rd_err ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
                  rd_state <= RD_RESP;
               end
            end
            RD_RESP: begin
               if (rready) begin
                  rd_state <= RD_IDLE;
               end
            end
            default: begin
               rd_state <= RD_IDLE;
            end
         endcase
      end
   end
endmodule

// *** logic/ifsb_top.v ***
// How it works
// RULE1: flag reads one while request pending
// RULE2: unimplemented bits read zero, ignore writes
// RULE3: reset clears every flag
// RULE4: software reads and writes every flag
// RULE5: register zero upper byte source layout
// RULE6: register zero lower byte source layout
// RULE7: register one upper byte source layout
// RULE8: register one lower byte source layout
// RULE9: register two upper byte source layout
// RULE10: register two lower byte source layout
// RULE11: register three holds five sources only
// RULE12: source sets flag, software clears it
// RULE13: request beats same-cycle software clear
`timescale 1ns/1ps
`include "ifsb_defines.vh"

module ifsb_top (
   input  wire                 CLOCK,
   input  wire                 RESET_N,
   // axi4-lite register port
   input  wire                 AWVALID,
   output wire                 AWREADY,
   input  wire [`IFSB_AW-1:0]  AWADDR,
   input  wire                 WVALID,
   output wire                 WREADY,
   input  wire [`IFSB_DW-1:0]  WDATA,
   input  wire [3:0]           WSTRB,
   output wire                 BVALID,
   input  wire                 BREADY,
   output wire [1:0]           BRESP,
   input  wire                 ARVALID,
   output wire                 ARREADY,
   input  wire [`IFSB_AW-1:0]  ARADDR,
   output wire                 RVALID,
   input  wire                 RREADY,
   output wire [`IFSB_DW-1:0]  RDATA,
   output wire [1:0]           RRESP,
   // flag register 0 sources
   input  wire                 ADC_DONE_REQ,
   input  wire                 UART_A_TX_REQ,
   input  wire                 UART_A_RX_REQ,
   input  wire                 SPI_A_EVENT_REQ,
   input  wire                 SPI_A_FAULT_REQ,
   input  wire                 TIMER_C_REQ,
   input  wire                 TIMER_B_REQ,
   input  wire                 COMPARE_B_REQ,
   input  wire                 CAPTURE_B_REQ,
   input  wire                 TIMER_A_REQ,
   input  wire                 COMPARE_A_REQ,
   input  wire                 CAPTURE_A_REQ,
   input  wire                 EXT_IRQ_A_REQ,
   // flag register 1 sources
   input  wire                 UART_B_TX_REQ,
   input  wire                 UART_B_RX_REQ,
   input  wire                 EXT_IRQ_C_REQ,
   input  wire                 TIMER_E_REQ,
   input  wire                 TIMER_D_REQ,
   input  wire                 COMPARE_D_REQ,
   input  wire                 COMPARE_C_REQ,
   input  wire                 CAPTURE_H_REQ,
   input  wire                 CAPTURE_G_REQ,
   input  wire                 EXT_IRQ_B_REQ,
   input  wire                 PIN_CHANGE_REQ,
   input  wire                 COMPARATOR_REQ,
   input  wire                 I2C_A_MASTER_REQ,
   input  wire                 I2C_A_SLAVE_REQ,
   // flag register 2 sources
   input  wire                 PARALLEL_PORT_REQ,
   input  wire                 COMPARE_H_REQ,
   input  wire                 COMPARE_G_REQ,
   input  wire                 COMPARE_F_REQ,
   input  wire                 COMPARE_E_REQ,
   input  wire                 CAPTURE_F_REQ,
   input  wire                 CAPTURE_E_REQ,
   input  wire                 CAPTURE_D_REQ,
   input  wire                 CAPTURE_C_REQ,
   input  wire                 SPI_B_EVENT_REQ,
   input  wire                 SPI_B_FAULT_REQ,
   // flag register 3 sources
   input  wire                 CALENDAR_REQ,
   input  wire                 EXT_IRQ_E_REQ,
   input  wire                 EXT_IRQ_D_REQ,
   input  wire                 I2C_B_MASTER_REQ,
   input  wire                 I2C_B_SLAVE_REQ,
   // flags toward priority logic
   output wire [`IFSB_FW-1:0]  FLAGS_0,
   output wire [`IFSB_FW-1:0]  FLAGS_1,
   output wire [`IFSB_FW-1:0]  FLAGS_2,
   output wire [`IFSB_FW-1:0]  FLAGS_3,
   // summary interrupt
   output wire                 IRQ
);

   // address to register select, used by read and write
   function [2:0] reg_sel;
      input [`IFSB_AW-1:0] addr;
      begin
         case (addr)
            `IFSB_OFS_FLAGS0: reg_sel = `IFSB_SEL_F0;
            `IFSB_OFS_FLAGS1: reg_sel = `IFSB_SEL_F1;
            `IFSB_OFS_FLAGS2: reg_sel = `IFSB_SEL_F2;
            `IFSB_OFS_FLAGS3: reg_sel = `IFSB_SEL_F3;
            `IFSB_OFS_STATUS: reg_sel = `IFSB_SEL_STAT;
            `IFSB_OFS_CLEAR:  reg_sel = `IFSB_SEL_CLR;
            `IFSB_OFS_ENABLE: reg_sel = `IFSB_SEL_EN;
            default:          reg_sel = `IFSB_SEL_NONE;
         endcase
      end
   endfunction

   // bus-side strobes
   wire                wr_en;   // write performed this cycle
   wire [`IFSB_AW-1:0] wr_addr; // held write address
   wire [`IFSB_DW-1:0] wr_data; // held write data
   wire [3:0]          wr_strb; // held byte lanes
   wire                rd_en;   // read taken this cycle
   wire [2:0]          wsel;    // decoded write target
   wire [2:0]          rsel;    // decoded read target
   reg  [`IFSB_DW-1:0] rd_data; // read mux value

   // request vectors per flag register
   reg  [`IFSB_FW-1:0] req_0;
   reg  [`IFSB_FW-1:0] req_1;
   reg  [`IFSB_FW-1:0] req_2;
   reg  [`IFSB_FW-1:0] req_3;

   // event status, enable, clear
   wire [`IFSB_EW-1:0] evt;         // new request per register
   reg  [`IFSB_EW-1:0] evt_status;  // sticky event bits
   reg  [`IFSB_EW-1:0] evt_enable;  // event enables
   reg  [`IFSB_EW-1:0] evt_clear;   // write-one clear pulse
   reg  [`IFSB_EW-1:0] next_status; // next sticky value

   assign wsel = reg_sel(wr_addr);
   assign rsel = reg_sel(ARADDR);

   // axi4-lite front end
   ifsb_axi_slave u_bus (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .awvalid (AWVALID),
      .awready (AWREADY),
      .awaddr  (AWADDR),
      .wvalid  (WVALID),
      .wready  (WREADY),
      .wdata   (WDATA),
      .wstrb   (WSTRB),
      .bvalid  (BVALID),
      .bready  (BREADY),
      .bresp   (BRESP),
      .arvalid (ARVALID),
      .arready (ARREADY),
      .araddr  (ARADDR),
      .rvalid  (RVALID),
      .rready  (RREADY),
      .rdata   (RDATA),
      .rresp   (RRESP),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wsel == `IFSB_SEL_NONE),
      .rd_en   (rd_en),
      .rd_data (rd_data),
      .rd_err  (rsel == `IFSB_SEL_NONE)
   );

   // route each source onto its documented bit
   always @* begin
      req_0 = `IFSB_FLAG_RST;
      req_1 = `IFSB_FLAG_RST;
      req_2 = `IFSB_FLAG_RST;
      req_3 = `IFSB_FLAG_RST;
      // register 0, upper byte
      req_0[`IFSB_ADC_DONE]   = ADC_DONE_REQ; // RULE5
      req_0[`IFSB_UART_A_TX]  = UART_A_TX_REQ;
      req_0[`IFSB_UART_A_RX]  = UART_A_RX_REQ;
      req_0[`IFSB_SPI_A_EVT]  = SPI_A_EVENT_REQ;
      req_0[`IFSB_SPI_A_FLT]  = SPI_A_FAULT_REQ;
      req_0[`IFSB_TIMER_C]    = TIMER_C_REQ;
      // register 0, lower byte
      req_0[`IFSB_TIMER_B]    = TIMER_B_REQ; // RULE6
      req_0[`IFSB_CMP_B]      = COMPARE_B_REQ;
      req_0[`IFSB_CAP_B]      = CAPTURE_B_REQ;
      req_0[`IFSB_TIMER_A]    = TIMER_A_REQ;
      req_0[`IFSB_CMP_A]      = COMPARE_A_REQ;
      req_0[`IFSB_CAP_A]      = CAPTURE_A_REQ;
      req_0[`IFSB_EXT_A]      = EXT_IRQ_A_REQ;
      // register 1, upper byte
      req_1[`IFSB_UART_B_TX]  = UART_B_TX_REQ; // RULE7
      req_1[`IFSB_UART_B_RX]  = UART_B_RX_REQ;
      req_1[`IFSB_EXT_C]      = EXT_IRQ_C_REQ;
      req_1[`IFSB_TIMER_E]    = TIMER_E_REQ;
      req_1[`IFSB_TIMER_D]    = TIMER_D_REQ;
      req_1[`IFSB_CMP_D]      = COMPARE_D_REQ;
      req_1[`IFSB_CMP_C]      = COMPARE_C_REQ;
      // register 1, lower byte
      req_1[`IFSB_CAP_H]      = CAPTURE_H_REQ; // RULE8
      req_1[`IFSB_CAP_G]      = CAPTURE_G_REQ;
      req_1[`IFSB_EXT_B]      = EXT_IRQ_B_REQ;
      req_1[`IFSB_PIN_CHG]    = PIN_CHANGE_REQ;
      req_1[`IFSB_COMPARATOR] = COMPARATOR_REQ;
      req_1[`IFSB_I2C_A_MST]  = I2C_A_MASTER_REQ;
      req_1[`IFSB_I2C_A_SLV]  = I2C_A_SLAVE_REQ;
      // register 2, upper byte
      req_2[`IFSB_PAR_PORT]   = PARALLEL_PORT_REQ; // RULE9
      req_2[`IFSB_CMP_H]      = COMPARE_H_REQ;
      req_2[`IFSB_CMP_G]      = COMPARE_G_REQ;
      req_2[`IFSB_CMP_F]      = COMPARE_F_REQ;
      req_2[`IFSB_CMP_E]      = COMPARE_E_REQ;
      req_2[`IFSB_CAP_F]      = CAPTURE_F_REQ;
      // register 2, lower byte
      req_2[`IFSB_CAP_E]      = CAPTURE_E_REQ; // RULE10
      req_2[`IFSB_CAP_D]      = CAPTURE_D_REQ;
      req_2[`IFSB_CAP_C]      = CAPTURE_C_REQ;
      req_2[`IFSB_SPI_B_EVT]  = SPI_B_EVENT_REQ;
      req_2[`IFSB_SPI_B_FLT]  = SPI_B_FAULT_REQ;
      // register 3, sparse
      req_3[`IFSB_CALENDAR]   = CALENDAR_REQ; // RULE11
      req_3[`IFSB_EXT_E]      = EXT_IRQ_E_REQ;
      req_3[`IFSB_EXT_D]      = EXT_IRQ_D_REQ;
      req_3[`IFSB_I2C_B_MST]  = I2C_B_MASTER_REQ;
      req_3[`IFSB_I2C_B_SLV]  = I2C_B_SLAVE_REQ;
   end

   // flag register 0; mask keeps unused bits at zero
   ifsb_flag_reg #(
      .MASK (`IFSB_MASK0) // RULE2
   ) u_flags_0 (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .wr      (wr_en && (wsel == `IFSB_SEL_F0)),
      .wdata   (wr_data[`IFSB_FW-1:0]),
      .wstrb   (wr_strb[1:0]),
      .req     (req_0),
      .flags   (FLAGS_0),
      .evt     (evt[0])
   );

   // flag register 1
   ifsb_flag_reg #(
      .MASK (`IFSB_MASK1) // RULE2
   ) u_flags_1 (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .wr      (wr_en && (wsel == `IFSB_SEL_F1)),
      .wdata   (wr_data[`IFSB_FW-1:0]),
      .wstrb   (wr_strb[1:0]),
      .req     (req_1),
      .flags   (FLAGS_1),
      .evt     (evt[1])
   );

   // flag register 2
   ifsb_flag_reg #(
      .MASK (`IFSB_MASK2) // RULE2
   ) u_flags_2 (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .wr      (wr_en && (wsel == `IFSB_SEL_F2)),
      .wdata   (wr_data[`IFSB_FW-1:0]),
      .wstrb   (wr_strb[1:0]),
      .req     (req_2),
      .flags   (FLAGS_2),
      .evt     (evt[2])
   );

   // flag register 3
   ifsb_flag_reg #(
      .MASK (`IFSB_MASK3) // RULE2
   ) u_flags_3 (
      .clock   (CLOCK),
      .reset_n (RESET_N),
      .wr      (wr_en && (wsel == `IFSB_SEL_F3)),
      .wdata   (wr_data[`IFSB_FW-1:0]),
      .wstrb   (wr_strb[1:0]),
      .req     (req_3),
      .flags   (FLAGS_3),
      .evt     (evt[3])
   );

   // write-one clear pulse for the event status
   always @* begin
      evt_clear = `IFSB_EVT_RST;
      if (wr_en && (wsel == `IFSB_SEL_CLR) && wr_strb[0]) begin
         evt_clear = wr_data[`IFSB_EW-1:0];
      end
   end

   // sticky status: a new event outlives its own clear
   always @* begin
      next_status = (evt_status & ~evt_clear) | evt;
   end

   // status and enable registers
   always @(posedge CLOCK) begin
      if (!RESET_N) begin
         evt_status <= `IFSB_EVT_RST;
         evt_enable <= `IFSB_EVT_RST;
      end else begin
         evt_status <= next_status;
         if (wr_en && (wsel == `IFSB_SEL_EN) && wr_strb[0]) begin
            evt_enable <= wr_data[`IFSB_EW-1:0];
         end
      end
   end

   // level interrupt while any enabled event is pending
   assign IRQ = |(evt_status & evt_enable);

   // read mux; flags zero-extended, clear reads zero
   always @* begin
      rd_data = `IFSB_ZERO32;
      case (rsel)
         `IFSB_SEL_F0: begin
            rd_data[`IFSB_FW-1:0] = FLAGS_0; // RULE1
         end
         `IFSB_SEL_F1: begin
            rd_data[`IFSB_FW-1:0] = FLAGS_1; // RULE1
         end
         `IFSB_SEL_F2: begin
            rd_data[`IFSB_FW-1:0] = FLAGS_2; // RULE1
         end
         `IFSB_SEL_F3: begin
            rd_data[`IFSB_FW-1:0] = FLAGS_3; // RULE1
         end
         `IFSB_SEL_STAT: begin
            rd_data[`IFSB_EW-1:0] = evt_status;
         end
         `IFSB_SEL_EN: begin
            rd_data[`IFSB_EW-1:0] = evt_enable;
         end
         default: begin
            rd_data = `IFSB_ZERO32;
         end
      endcase
   end

   // rd_en is only a timing marker for the front end
   wire unused_rd = rd_en;

endmodule

// *** tb/ifsb_src_model.sv ***
`timescale 1ns/1ps

// stand-in for the peripherals and pins that raise requests
module ifsb_src_model (
   input  wire logic        clock,  // shared bus clock
   output logic      [63:0] req     // lane i feeds flag register i
);
   // sources idle low between events
   initial req = 64'h0000000000000000;

   // drive one lane for n cycles, then drop all
   task automatic pulse(input int idx, input logic [15:0] pat, input int n);
      @(posedge clock);
      req[idx*16 +: 16] <= pat;
      repeat (n) @(posedge clock);
      req <= 64'h0000000000000000;
   endtask
endmodule

// *** tb/ifsb_sva.sv ***
`timescale 1ns/1ps

// port-level checks for the flag bank
module ifsb_sva (
   input wire logic        CLOCK,
   input wire logic        RESET_N,
   input wire logic [15:0] FLAGS_0,
   input wire logic [15:0] FLAGS_1,
   input wire logic [15:0] FLAGS_2,
   input wire logic [15:0] FLAGS_3,
   input wire logic        EXT_IRQ_A_REQ,
   input wire logic        CALENDAR_REQ,
   input wire logic        ARVALID,
   input wire logic        ARREADY,
   input wire logic        RVALID,
   input wire logic        RREADY,
   input wire logic [31:0] RDATA,
   input wire logic        BVALID,
   input wire logic        BREADY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);

   // read address accepted
   sequence ar_take;
      ARVALID && ARREADY;
   endsequence
   // read data held back
   sequence r_wait;
      RVALID && !RREADY;
   endsequence

   unimpl_zero_a: assert property (
      ((FLAGS_0 & 16'hC010) | (FLAGS_1 & 16'h0120) | (FLAGS_2 & 16'hC01C)
       | (FLAGS_3 & 16'hBF99)) == 16'h0000)
      else $error("unimplemented flag bit set");
   reset_clear_a: assert property (
      $rose(RESET_N) |-> {FLAGS_3, FLAGS_2, FLAGS_1, FLAGS_0} == 64'h0000000000000000)
      else $error("flags not clear after reset");
   req_sets_a: assert property (
      EXT_IRQ_A_REQ |=> FLAGS_0[0])
      else $error("request did not set its flag");
   calendar_sets_a: assert property (
      CALENDAR_REQ |=> FLAGS_3[14])
      else $error("calendar request lost");
   clear_by_write_a: assert property (
      $fell(FLAGS_0[0]) && $past(RESET_N) |-> $rose(BVALID))
      else $error("flag dropped without a write");
   read_answer_a: assert property (
      ar_take |=> RVALID)
      else $error("read not answered next cycle");
   read_holds_a: assert property (
      r_wait |=> RVALID && $stable(RDATA))
      else $error("read data not held");
   ar_refused_a: assert property (
      RVALID |-> !ARREADY)
      else $error("read address taken mid-read");
   resp_retire_a: assert property (
      BVALID && BREADY |=> !BVALID)
      else $error("write response not retired");
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps

// self-checking bench for the flag bank
module testbench;
   typedef struct {int r; logic [15:0] p; logic [15:0] e;} ifsb_row_t;
   logic        CLOCK = 1'b0, RESET_N = 1'b0;          // clock and held reset
   logic        AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
   logic        BREADY = 1'b1, RREADY = 1'b1;          // bready stays up
   logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h00000000;
   logic [3:0]  WSTRB = 4'hF;
   wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
   wire  [1:0]  BRESP, RRESP;
   wire  [31:0] RDATA;
   wire  [15:0] FLAGS_0, FLAGS_1, FLAGS_2, FLAGS_3;
   wire  [63:0] q;
   wire  [63:0] flv = {FLAGS_3, FLAGS_2, FLAGS_1, FLAGS_0};
   logic [31:0] rdat;
   logic [1:0]  rres, br;
   int          error_cnt = 0, cmp_count = 0;
   // lane, request pattern, expected flags
   ifsb_row_t   rows [8] = '{
      '{0, 16'h5555, 16'h1545}, '{0, 16'hAAAA, 16'h2AAA},
      '{1, 16'h5555, 16'h5455}, '{1, 16'hAAAA, 16'hAA8A},
      '{2, 16'h5555, 16'h1541}, '{2, 16'hAAAA, 16'h2AA2},
      '{3, 16'h5555, 16'h4044}, '{3, 16'hAAAA, 16'h0022}};

   // 4 ns period
   always #2 CLOCK = ~CLOCK;

   ifsb_src_model ifsb_src_model_i (.clock(CLOCK), .req(q));
   ifsb_top ifsb_top_i (
      .CLOCK, .RESET_N, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
      .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA,
      .RRESP, .FLAGS_0, .FLAGS_1, .FLAGS_2, .FLAGS_3, .IRQ,
      .ADC_DONE_REQ(q[13]), .UART_A_TX_REQ(q[12]), .UART_A_RX_REQ(q[11]),
      .SPI_A_EVENT_REQ(q[10]), .SPI_A_FAULT_REQ(q[9]), .TIMER_C_REQ(q[8]),
      .TIMER_B_REQ(q[7]), .COMPARE_B_REQ(q[6]), .CAPTURE_B_REQ(q[5]),
      .TIMER_A_REQ(q[3]), .COMPARE_A_REQ(q[2]), .CAPTURE_A_REQ(q[1]), .EXT_IRQ_A_REQ(q[0]),
      .UART_B_TX_REQ(q[31]), .UART_B_RX_REQ(q[30]), .EXT_IRQ_C_REQ(q[29]),
      .TIMER_E_REQ(q[28]), .TIMER_D_REQ(q[27]), .COMPARE_D_REQ(q[26]), .COMPARE_C_REQ(q[25]),
      .CAPTURE_H_REQ(q[23]), .CAPTURE_G_REQ(q[22]), .EXT_IRQ_B_REQ(q[20]),
      .PIN_CHANGE_REQ(q[19]), .COMPARATOR_REQ(q[18]), .I2C_A_MASTER_REQ(q[17]),
      .I2C_A_SLAVE_REQ(q[16]), .PARALLEL_PORT_REQ(q[45]), .COMPARE_H_REQ(q[44]),
      .COMPARE_G_REQ(q[43]), .COMPARE_F_REQ(q[42]), .COMPARE_E_REQ(q[41]),
      .CAPTURE_F_REQ(q[40]), .CAPTURE_E_REQ(q[39]), .CAPTURE_D_REQ(q[38]),
      .CAPTURE_C_REQ(q[37]), .SPI_B_EVENT_REQ(q[33]), .SPI_B_FAULT_REQ(q[32]),
      .CALENDAR_REQ(q[62]), .EXT_IRQ_E_REQ(q[54]), .EXT_IRQ_D_REQ(q[53]),
      .I2C_B_MASTER_REQ(q[50]), .I2C_B_SLAVE_REQ(q[49]));

   // compare one value, count it
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // report the end of a test
   task automatic done(input string n);
      $display("test %s done", n);
   endtask

   // axi4-lite write, address and data together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw = 1'b1, w = 1'b1;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (aw || w) begin
         @(posedge CLOCK);
         if (aw && AWREADY) begin
            aw = 1'b0;
            AWVALID <= 1'b0;
         end
         if (w && WREADY) begin
            w = 1'b0;
            WVALID <= 1'b0;
         end
      end
      while (!BVALID) @(posedge CLOCK);
      br = BRESP;
   endtask

   // axi4-lite read, rready held back lag cycles
   task automatic rd(input logic [7:0] a, input int lag = 0);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= (lag == 0);
      do @(posedge CLOCK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge CLOCK); while (!RVALID);
      if (lag > 0) begin
         repeat (lag) @(posedge CLOCK);
         RREADY <= 1'b1;
         @(posedge CLOCK);
      end
      rdat = RDATA;
      rres = RRESP;
   endtask

   // counts, verdict, stop
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge CLOCK);
      RESET_N <= 1'b1;
      @(posedge CLOCK);
      // each lane: raise, read, clear
      foreach (rows[k]) begin
         ifsb_src_model_i.pulse(rows[k].r, rows[k].p, 1);
         rd(8'(rows[k].r * 4));
         chk("flags read", {16'h0000, rows[k].e}, rdat);
         chk("flags port", {16'h0000, rows[k].e}, {16'h0000, flv[rows[k].r*16 +: 16]});
         wr(8'(rows[k].r * 4), 32'h00000000);
         chk("flags cleared", 32'h0, {16'h0000, flv[rows[k].r*16 +: 16]});
      end
      done("source table");
      // request in the cycle of a clearing write
      fork
         ifsb_src_model_i.pulse(0, 16'h0001, 1);
         wr(8'h00, 32'h00000000);
      join
      rd(8'h00);
      chk("set beats clear", 32'h00000001, rdat);
      wr(8'h00, 32'h00000000);
      // only implemented bits take a written one
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C);
      chk("written ones", 32'h00004066, rdat);
      wr(8'h0C, 32'h00000000);
      rd(8'h0C, 3);
      chk("slow read", 32'h00000000, rdat);
      // unmapped place
      rd(8'h20);
      chk("unmapped read", 32'h00000002, {30'h0, rres});
      wr(8'h20, 32'hFFFFFFFF);
      chk("unmapped write", 32'h00000002, {30'h0, br});
      done("write and refuse");
      // summary interrupt: raise, mask, unmask, clear
      wr(8'h14, 32'h0000000F);
      wr(8'h18, 32'h00000001);
      ifsb_src_model_i.pulse(0, 16'h0001, 1);
      rd(8'h10);
      chk("event status", 32'h00000001, rdat);
      chk("irq raised", 32'h00000001, {31'h0, IRQ});
      wr(8'h18, 32'h00000000);
      chk("irq masked", 32'h00000000, {31'h0, IRQ});
      wr(8'h18, 32'h00000001);
      chk("irq unmasked", 32'h00000001, {31'h0, IRQ});
      wr(8'h14, 32'h00000001);
      chk("irq cleared", 32'h00000000, {31'h0, IRQ});
      wr(8'h00, 32'h00000000);
      done("interrupt");
      // reset in mid-run wipes pending flags
      ifsb_src_model_i.pulse(1, 16'hFFFF, 1);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLOCK);
      RESET_N <= 1'b1;
      @(posedge CLOCK);
      chk("flags low after reset", 32'h0, flv[31:0]);
      chk("flags high after reset", 32'h0, flv[63:32]);
      rd(8'h04);
      chk("read after reset", 32'h00000000, rdat);
      done("reset");
      end_sim();
   end

   // hang guard at 50000 cycles
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end
endmodule

bind ifsb_top ifsb_sva ifsb_sva_i (
   .CLOCK, .RESET_N, .FLAGS_0, .FLAGS_1, .FLAGS_2, .FLAGS_3, .EXT_IRQ_A_REQ, .CALENDAR_REQ,
   .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .BVALID, .BREADY);
